//--- dv/queue_fill_model.sv
// fill model of the transmit and receive queues beside the block
`timescale 1ns/1ps
module queue_fill_model (
    input wire logic clock_in, // clock
    input wire logic rstn_in, // reset, active low
    input wire logic rx_push_in, // one character received
    input wire logic tx_push_in, // one character queued
    input wire logic rx_clear_in, // receive control reset
    input wire logic tx_clear_in, // transmit control reset
    output uart_shadow_pkg::level_t rx_level_out, // receive fill
    output uart_shadow_pkg::level_t tx_level_out // transmit fill
);
    import uart_shadow_pkg::*;
    // counters capped at full, emptied by the control resets
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_level_out <= 5'h00;
            tx_level_out <= 5'h00;
        end else begin
            if (rx_clear_in) rx_level_out <= 5'h00;
            else if (rx_push_in && rx_level_out != 5'h10)
                rx_level_out <= rx_level_out + 5'h01;
            if (tx_clear_in) tx_level_out <= 5'h00;
            else if (tx_push_in && tx_level_out != 5'h10)
                tx_level_out <= tx_level_out + 5'h01;
        end
    end
endmodule : queue_fill_model

//--- dv/shadow_props.sv
// checker for the queue control shadow block
`timescale 1ns/1ps
`include "uart_shadow_params.svh"
module shadow_props (
    input wire logic clock_in, rstn_in, read_in, write_in, // bus
    input wire logic [31:0] address_in, writedata_in, // bus words
    input wire logic [3:0] byteenable_in, // lanes
    input wire logic qcw_write_in, auto_flow_in, rts_bit_in, // strobes
    input wire uart_shadow_pkg::level_t rx_level_in, // receive fill
    input wire logic waitrequest_out, queue_enable_out, dma_mode_out,
    input wire logic [1:0] rx_trigger_out, // threshold code
    input wire logic tx_queue_reset_out, rx_queue_reset_out, // pulses
    input wire logic rx_avail_irq_out, rx_dma_req_n_out, rts_n_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    function automatic logic [4:0] thr_of(logic [1:0] c, logic e);
        return (!e || c == 2'h0) ? `THR_ONE_CHAR :
            (c == 2'h3) ? `THR_TWO_LESS : `THR_HALF_FULL;
    endfunction : thr_of
    // threshold and comparisons that decide the next outputs
    wire [4:0] th = thr_of(rx_trigger_out, queue_enable_out);
    wire hit = rx_level_in >= th;
    wire over = rx_level_in > th;
    wire m1 = dma_mode_out & queue_enable_out;
    // a shadow write taken at this edge
    sequence s_put(logic [31:0] a);
        write_in && !waitrequest_out && address_in == a && byteenable_in[0]
            && !qcw_write_in;
    endsequence
    a_wait_single: assert property (
        (read_in || write_in) && waitrequest_out
        |=> !waitrequest_out ##1 waitrequest_out) else $error("bad wait");
    a_dma_alone: assert property (
        s_put(`OFS_DMA_SEL_SHADOW) |=> dma_mode_out == $past(writedata_in[0])
        && $stable(queue_enable_out) && $stable(rx_trigger_out))
        else $error("dma shadow write");
    a_enable_alone: assert property (
        s_put(`OFS_QUEUE_EN_SHADOW) |=> queue_enable_out ==
        $past(writedata_in[0]) && $stable(dma_mode_out)
        && $stable(rx_trigger_out)) else $error("enable shadow write");
    a_trig_alone: assert property (
        s_put(`OFS_RX_THR_SHADOW) |=> rx_trigger_out ==
        $past(writedata_in[1:0]) && $stable(dma_mode_out)
        && $stable(queue_enable_out)) else $error("trigger shadow write");
    a_disable_resets: assert property (
        $fell(queue_enable_out) |-> tx_queue_reset_out && rx_queue_reset_out)
        else $error("no queue reset");
    a_avail_level: assert property (
        $past(rstn_in) |-> rx_avail_irq_out == $past(hit))
        else $error("data available level");
    a_req_mode_one: assert property (
        $past(rstn_in) && $past(m1) && $past(hit) |-> !rx_dma_req_n_out)
        else $error("mode 1 request");
    a_req_mode_zero: assert property (
        $past(rstn_in) && !$past(m1) |->
        rx_dma_req_n_out == ($past(rx_level_in) == 5'h00))
        else $error("mode 0 request");
    a_rts_gate: assert property (
        $past(rstn_in) |-> rts_n_out == ($past(auto_flow_in) &&
        $past(queue_enable_out) && $past(over) || !$past(rts_bit_in)))
        else $error("request to send");
endmodule : shadow_props

//--- dv/tb_uart_fifo_shadow_controls.sv
// self-checking bench for the queue control shadow block
`timescale 1ns/1ps
`include "uart_shadow_params.svh"
module tb_uart_fifo_shadow_controls;
    import uart_shadow_pkg::*;
    logic clock_in = 1'b0, rstn_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
    logic qcw_write_in = 1'b0, auto_flow_in = 1'b0, rts_bit_in = 1'b0;
    logic rx_push = 1'b0, tx_push = 1'b0;
    logic [31:0] address_in = 32'h0, writedata_in = 32'h0, readdata_out;
    logic [3:0] byteenable_in = 4'hF;
    logic [7:0] qcw_data_in = 8'h00;
    level_t rx_level_in, tx_level_in;
    logic waitrequest_out, queue_enable_out, dma_mode_out, irq_out;
    logic tx_queue_reset_out, rx_queue_reset_out, rx_avail_irq_out;
    logic rx_dma_req_n_out, tx_dma_req_n_out, rts_n_out;
    logic [1:0] rx_trigger_out;
    logic [31:0] q, d, r, adr[4];
    logic [3:0] e;
    int num_errors = 0, check_count = 0, k;
    always #10 clock_in = ~clock_in;
    uart_fifo_shadow_controls uart_fifo_shadow_controls_inst (.*);
    queue_fill_model queue_fill_model_inst (.clock_in, .rstn_in,
        .rx_push_in(rx_push), .tx_push_in(tx_push),
        .rx_clear_in(rx_queue_reset_out), .tx_clear_in(tx_queue_reset_out),
        .rx_level_out(rx_level_in), .tx_level_out(tx_level_in));
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, x);
        check_count++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [31:0] a, v);
        int n;
        n = 0;
        write_in <= w;
        read_in <= !w;
        address_in <= a;
        writedata_in <= v;
        do begin
            @(posedge clock_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 50);
        q = readdata_out;
        if (n >= 50) begin
            num_errors++;
            $display("[ERR] %0t bus timeout", $time);
            final_report();
        end
        write_in <= 1'b0;
        read_in <= 1'b0;
        @(posedge clock_in);
    endtask : bus
    task automatic ctl(input logic [7:0] v);
        qcw_data_in <= v;
        qcw_write_in <= 1'b1;
        @(posedge clock_in);
        qcw_write_in <= 1'b0;
        @(posedge clock_in);
    endtask : ctl
    task automatic push(input int n);
        repeat (n) begin
            rx_push <= 1'b1;
            @(posedge clock_in);
        end
        rx_push <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask : push
    function automatic int thr_exp(input logic [1:0] c);
        return c == 2'h0 ? `THR_ONE_CHAR : c == 2'h3 ? `THR_TWO_LESS :
            `THR_HALF_FULL;
    endfunction : thr_exp
    initial begin
        #2000000;
        num_errors++;
        $display("[ERR] %0t run timeout", $time);
        final_report();
    end
    initial begin
        void'($urandom(96461));
        adr = '{`OFS_DMA_SEL_SHADOW, `OFS_QUEUE_EN_SHADOW,
            `OFS_RX_THR_SHADOW, 32'h5000_10A0};
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        // unmapped write ignored, all places read zero
        bus(1'b1, adr[3], $urandom);
        for (k = 0; k < 4; k++) begin
            bus(1'b0, adr[k], 32'h0);
            chk(q, 32'h0);
        end
        // random full control words, then one shadow write each
        repeat (12) begin
            d = $urandom;
            r = $urandom;
            k = $urandom_range(2);
            tx_push <= d[8];
            ctl({d[7:6], 2'b00, d[3], 2'b00, d[0]});
            tx_push <= 1'b0;
            e = {d[7:6], d[0], d[3]};
            if (k == 2) e[3:2] = r[1:0];
            else e[k] = r[0];
            bus(1'b1, adr[k], r);
            chk({rx_trigger_out, queue_enable_out, dma_mode_out}, e);
            bus(1'b0, adr[k], 32'h0);
            chk(q, k == 2 ? r[1:0] : r[0]);
        end
        // every threshold code in mode 1, counting up to the trigger
        for (k = 0; k < 4; k++) begin
            ctl({k[1:0], 6'h0B});
            push(thr_exp(k[1:0]) - 1);
            chk(rx_avail_irq_out, 1'b0);
            push(1);
            chk(rx_avail_irq_out, 1'b1);
            chk(rx_dma_req_n_out, 1'b0);
        end
        // disable event masked, then unmasked, then cleared
        bus(1'b1, `OFS_EVENT_MASK, 32'h0);
        bus(1'b1, adr[1], 32'h0);
        @(posedge clock_in);
        chk(rx_level_in, 5'h00);
        chk(irq_out, 1'b0);
        bus(1'b1, `OFS_EVENT_MASK, 32'h2);
        @(posedge clock_in);
        chk(irq_out, 1'b1);
        chk(tx_dma_req_n_out, 1'b0);
        bus(1'b1, `OFS_EVENT_STATUS, 32'h2);
        @(posedge clock_in);
        chk(irq_out, 1'b0);
        // auto flow gating with a one character threshold
        auto_flow_in <= 1'b1;
        rts_bit_in <= 1'b1;
        bus(1'b1, adr[2], 32'h0);
        bus(1'b1, adr[1], 32'h1);
        push(1);
        chk(rts_n_out, 1'b0);
        push(1);
        chk(rts_n_out, 1'b1);
        final_report();
    end
endmodule : tb_uart_fifo_shadow_controls
bind uart_fifo_shadow_controls shadow_props shadow_props_inst (.clock_in,
    .rstn_in, .read_in, .write_in, .address_in, .writedata_in,
    .byteenable_in, .qcw_write_in, .auto_flow_in, .rts_bit_in, .rx_level_in,
    .waitrequest_out, .queue_enable_out, .dma_mode_out, .rx_trigger_out,
    .tx_queue_reset_out, .rx_queue_reset_out, .rx_avail_irq_out,
    .rx_dma_req_n_out, .rts_n_out);

//--- src/rx_threshold_compare.sv
// receive queue threshold decoder and fill level comparator
`timescale 1ns/1ps
`include "uart_shadow_params.svh"

module rx_threshold_compare (
    input wire uart_shadow_pkg::trig_code_t code_in, // threshold code
    input wire uart_shadow_pkg::level_t level_in, // receive fill level
    output logic reached_out, // level at or above threshold
    output logic above_out // level strictly above threshold
);
    import uart_shadow_pkg::*;

    level_t threshold;

    // map the two-bit code to a character count
    always_comb begin
        case (code_in)
            2'h0: threshold = `THR_ONE_CHAR;
            2'h1: threshold = `THR_HALF_FULL;
            2'h2: threshold = `THR_HALF_FULL;
            2'h3: threshold = `THR_TWO_LESS;
            default: threshold = `THR_ONE_CHAR;
        endcase
    end

    // compare the fill level against the chosen threshold
    assign reached_out = (level_in >= threshold);
    assign above_out = (level_in > threshold);

endmodule : rx_threshold_compare

//--- src/uart_fifo_shadow_controls.sv
// shadow controls for the uart queue control word, with avalon slave
// Summary of operation
// - dma mode shadow bit, writes touch nothing else
// - dma mode picks request signalling scheme with queues on
// - queue enable shadow gates both queues
// - enable falling resets both queue controls
// - receive threshold shadow, writes touch nothing else
// - data available interrupt at receive threshold with queues on, else one character
// - mode 1 receive request low from threshold until empty
// - codes: one, half, half, two less
// - auto flow: rts high above threshold with queues on
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "uart_shadow_params.svh"

module uart_fifo_shadow_controls (
    input wire logic clock_in, // 50 MHz clock
    input wire logic rstn_in, // async reset, active low
    input wire logic [31:0] address_in, // avalon byte address
    input wire logic read_in, // avalon read
    input wire logic write_in, // avalon write
    input wire logic [31:0] writedata_in, // avalon write data
    input wire logic [3:0] byteenable_in, // avalon byte enables
    output logic [31:0] readdata_out, // avalon read data
    output logic waitrequest_out, // avalon wait request
    input wire logic qcw_write_in, // full control word write strobe
    input wire logic [7:0] qcw_data_in, // full control word value
    input wire uart_shadow_pkg::level_t rx_level_in, // receive fill
    input wire uart_shadow_pkg::level_t tx_level_in, // transmit fill
    input wire logic auto_flow_in, // modem control auto flow bit
    input wire logic rts_bit_in, // modem control request bit
    output logic queue_enable_out, // both queues enabled
    output logic dma_mode_out, // current dma signalling mode
    output logic [1:0] rx_trigger_out, // current threshold code
    output logic tx_queue_reset_out, // transmit control reset pulse
    output logic rx_queue_reset_out, // receive control reset pulse
    output logic rx_avail_irq_out, // received data available
    output logic rx_dma_req_n_out, // receive dma request, low
    output logic tx_dma_req_n_out, // transmit dma request, low
    output logic rts_n_out, // request to send, low
    output logic irq_out // unmasked event interrupt
);
    import uart_shadow_pkg::*;

    shadow_state_t st;
    shadow_state_t next_st;
    logic rx_reached;
    logic rx_above;
    logic [31:0] read_mux;
    logic bus_write;
    logic lane0;

    // threshold compare for the receive queue
    rx_threshold_compare thr_cmp (
        .code_in(st.rx_trig),
        .level_in(rx_level_in),
        .reached_out(rx_reached),
        .above_out(rx_above)
    );

    // write takes effect when waitrequest is low
    assign bus_write = (st.phase == phase_answer) && write_in;
    assign lane0 = byteenable_in[0];

    // read data selection, reserved bits read zero
    always_comb begin
        read_mux = 32'h0000_0000;
        case (address_in)
            `OFS_DMA_SEL_SHADOW: read_mux[0] = st.dma_mode;
            `OFS_QUEUE_EN_SHADOW: read_mux[0] = st.queue_en;
            `OFS_RX_THR_SHADOW: read_mux[1:0] = st.rx_trig;
            `OFS_EVENT_STATUS: read_mux[1:0] = st.status;
            `OFS_EVENT_MASK: read_mux[1:0] = st.mask;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        logic set_rx_evt;
        logic set_dis_evt;
        logic [1:0] clr;
        logic rx_level_ok;
        set_rx_evt = 1'b0;
        set_dis_evt = 1'b0;
        clr = 2'h0;
        rx_level_ok = 1'b0;
        next_st = st;
        next_st.tx_reset = 1'b0;
        next_st.rx_reset = 1'b0;

        // avalon handshake: one wait cycle, then answer
        case (st.phase)
            phase_wait: begin
                if (read_in || write_in) begin
                    next_st.phase = phase_answer;
                    next_st.readdata = read_in ? read_mux : 32'h0000_0000;
                end
            end
            phase_answer: begin
                next_st.phase = phase_wait;
            end
            default: next_st.phase = phase_wait;
        endcase

        // full control word write updates every field
        if (qcw_write_in) begin
            next_st.queue_en = qcw_data_in[`QCW_ENABLE_BIT];
            next_st.dma_mode = qcw_data_in[`QCW_DMA_MODE_BIT];
            next_st.rx_trig =
                qcw_data_in[`QCW_RX_TRIG_MSB:`QCW_RX_TRIG_LSB];
            next_st.rx_reset = qcw_data_in[`QCW_RX_RESET_BIT];
            next_st.tx_reset = qcw_data_in[`QCW_TX_RESET_BIT];
        end

        // shadow writes, each touches only its own field
        if (bus_write && lane0) begin
            case (address_in)
                `OFS_DMA_SEL_SHADOW:
                    next_st.dma_mode = writedata_in[0];
                `OFS_QUEUE_EN_SHADOW:
                    next_st.queue_en = writedata_in[0];
                `OFS_RX_THR_SHADOW:
                    next_st.rx_trig = writedata_in[1:0];
                `OFS_EVENT_STATUS: clr = writedata_in[1:0];
                `OFS_EVENT_MASK: next_st.mask = writedata_in[1:0];
                default: ;
            endcase
        end

        // disabling the queues resets both control portions
        if (st.queue_en && !next_st.queue_en) begin
            next_st.tx_reset = 1'b1;
            next_st.rx_reset = 1'b1;
            set_dis_evt = 1'b1;
        end

        // threshold applies with queues on, else one character
        rx_level_ok = st.queue_en ? rx_reached : (rx_level_in != 5'h00);
        next_st.rx_avail_irq = rx_level_ok;
        next_st.rx_reached_d = rx_level_ok;
        set_rx_evt = rx_level_ok && !st.rx_reached_d;

        // receive dma request: mode 0 any data, mode 1 threshold
        if (!st.dma_mode || !st.queue_en) begin
            next_st.rx_req_n = (rx_level_in == 5'h00);
        end else if (rx_reached) begin
            next_st.rx_req_n = 1'b0;
        end else if (rx_level_in == 5'h00) begin
            next_st.rx_req_n = 1'b1;
        end

        // transmit dma request: mode 0 empty, mode 1 until full
        if (!st.dma_mode || !st.queue_en) begin
            next_st.tx_req_n = (tx_level_in != 5'h00);
        end else if (tx_level_in == 5'h00) begin
            next_st.tx_req_n = 1'b0;
        end else if (tx_level_in >= `QUEUE_DEPTH) begin
            next_st.tx_req_n = 1'b1;
        end

        // request to send, gated by threshold under auto flow with queues on
        if (auto_flow_in && st.queue_en && rx_above) begin
            next_st.rts_n = 1'b1;
        end else begin
            next_st.rts_n = !rts_bit_in;
        end

        // sticky events, a new event wins over a clear
        next_st.status = (st.status & ~clr);
        next_st.status[`EVT_RX_THRESHOLD_BIT] =
            next_st.status[`EVT_RX_THRESHOLD_BIT] | set_rx_evt;
        next_st.status[`EVT_QUEUE_DISABLE_BIT] =
            next_st.status[`EVT_QUEUE_DISABLE_BIT] | set_dis_evt;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // state register, all fields reset to zero or idle
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st.phase <= phase_wait;
            st.readdata <= 32'h0000_0000;
            st.dma_mode <= `RST_DMA_MODE;
            st.queue_en <= `RST_QUEUE_EN;
            st.rx_trig <= `RST_RX_TRIG;
            st.tx_reset <= 1'b0;
            st.rx_reset <= 1'b0;
            st.status <= `RST_EVENTS;
            st.mask <= `RST_EVENTS;
            st.irq <= 1'b0;
            st.rx_avail_irq <= 1'b0;
            st.rx_reached_d <= 1'b0;
            st.rx_req_n <= 1'b1;
            st.tx_req_n <= 1'b1;
            st.rts_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign readdata_out = st.readdata;
    assign waitrequest_out = (st.phase == phase_wait);
    assign queue_enable_out = st.queue_en;
    assign dma_mode_out = st.dma_mode;
    assign rx_trigger_out = st.rx_trig;
    assign tx_queue_reset_out = st.tx_reset;
    assign rx_queue_reset_out = st.rx_reset;
    assign rx_avail_irq_out = st.rx_avail_irq;
    assign rx_dma_req_n_out = st.rx_req_n;
    assign tx_dma_req_n_out = st.tx_req_n;
    assign rts_n_out = st.rts_n;
    assign irq_out = st.irq;

endmodule : uart_fifo_shadow_controls

//--- src/uart_shadow_params.svh
// constants for the queue control shadow register block
`ifndef UART_SHADOW_PARAMS_SVH
`define UART_SHADOW_PARAMS_SVH

// register byte addresses
`define OFS_DMA_SEL_SHADOW 32'h5000_1094
`define OFS_QUEUE_EN_SHADOW 32'h5000_1098
`define OFS_RX_THR_SHADOW 32'h5000_109C
`define OFS_EVENT_STATUS 32'h5000_10B0
`define OFS_EVENT_MASK 32'h5000_10B4

// field positions in the queue control word
`define QCW_ENABLE_BIT 0
`define QCW_RX_RESET_BIT 1
`define QCW_TX_RESET_BIT 2
`define QCW_DMA_MODE_BIT 3
`define QCW_RX_TRIG_LSB 6
`define QCW_RX_TRIG_MSB 7

// event status bit positions
`define EVT_RX_THRESHOLD_BIT 0
`define EVT_QUEUE_DISABLE_BIT 1

// reset values
`define RST_DMA_MODE 1'h0
`define RST_QUEUE_EN 1'h0
`define RST_RX_TRIG 2'h0
`define RST_EVENTS 2'h0

// queue geometry and threshold levels
`define QUEUE_DEPTH 5'h10
`define THR_ONE_CHAR 5'h01
`define THR_HALF_FULL 5'h08
`define THR_TWO_LESS 5'h0E

`endif

//--- src/uart_shadow_pkg.sv
// types shared by the queue control shadow register block
package uart_shadow_pkg;

    typedef logic [4:0] level_t;
    typedef logic [1:0] trig_code_t;

    // bus answer phase, gray ordered
    typedef enum logic [0:0] {
        phase_wait = 1'b0,
        phase_answer = 1'b1
    } bus_phase_t;

    // complete state of the shadow control block
    typedef struct packed {
        bus_phase_t phase;
        logic [31:0] readdata;
        logic dma_mode;
        logic queue_en;
        trig_code_t rx_trig;
        logic tx_reset;
        logic rx_reset;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic rx_avail_irq;
        logic rx_reached_d;
        logic rx_req_n;
        logic tx_req_n;
        logic rts_n;
    } shadow_state_t;

endpackage : uart_shadow_pkg
